// ===== core/mcit_pkg.sv
/*
 * Shared constants and types for the instruction decode and timing block:
 * opcode values, encoding lengths, cycle counts, operand field positions,
 * the enumerations of addressing, target and condition kinds, the
 * sequencer state and a builder for decode rows.
 * Assumes the importing modules run on one clock and share these names.
 */
package mcit_pkg;

	// ----------------------------------------------------------------
	// widths and field positions
	// ----------------------------------------------------------------
	localparam int PC_W = 16;
	localparam int PAGE_W = 11;
	localparam int BANK_LO_POS = 3;
	localparam int BANK_HI_POS = 4;
	localparam int HALF_POS = 7;
	localparam logic [7:0] BIT_BYTE_BASE = 8'h20;

	// ----------------------------------------------------------------
	// encoding lengths and cycle counts
	// ----------------------------------------------------------------
	localparam logic [1:0] LEN_ONE = 2'h1;
	localparam logic [1:0] LEN_TWO = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;
	localparam logic [2:0] CYC_ONE = 3'h1;
	localparam logic [2:0] CYC_TWO = 3'h2;
	localparam logic [2:0] CYC_THREE = 3'h3;
	localparam logic [2:0] CYC_FOUR = 3'h4;
	localparam logic [2:0] CYC_FIVE = 3'h5;

	// ----------------------------------------------------------------
	// whole opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_IDLE = 8'h00;
	localparam logic [7:0] OP_SPARE = 8'hA5;
	localparam logic [7:0] OP_ROTR_CARRY = 8'h13;
	localparam logic [7:0] OP_NIB_SWAP = 8'hC4;
	localparam logic [7:0] OP_CP_A_DIR = 8'hE5;
	localparam logic [7:0] OP_CP_A_IMM = 8'h74;
	localparam logic [7:0] OP_CP_DIR_A = 8'hF5;
	localparam logic [7:0] OP_CP_DD = 8'h85;
	localparam logic [7:0] OP_CP_DIR_IMM = 8'h75;
	localparam logic [7:0] OP_LOAD_DP = 8'h90;
	localparam logic [7:0] OP_CODE_DP = 8'h93;
	localparam logic [7:0] OP_CODE_PC = 8'h83;
	localparam logic [7:0] OP_EXT_RD_DP = 8'hE0;
	localparam logic [7:0] OP_EXT_WR_DP = 8'hF0;
	localparam logic [7:0] OP_STACK_PUT = 8'hC0;
	localparam logic [7:0] OP_STACK_GET = 8'hD0;
	localparam logic [7:0] OP_EXG_DIR = 8'hC5;
	localparam logic [7:0] OP_CARRY_CLR = 8'hC3;
	localparam logic [7:0] OP_CARRY_SET = 8'hD3;
	localparam logic [7:0] OP_CARRY_CPL = 8'hB3;
	localparam logic [7:0] OP_BIT_CLR = 8'hC2;
	localparam logic [7:0] OP_BIT_SET = 8'hD2;
	localparam logic [7:0] OP_BIT_CPL = 8'hB2;
	localparam logic [7:0] OP_AND_BIT = 8'h82;
	localparam logic [7:0] OP_AND_NBIT = 8'hB0;
	localparam logic [7:0] OP_OR_BIT = 8'h72;
	localparam logic [7:0] OP_OR_NBIT = 8'hA0;
	localparam logic [7:0] OP_CP_C_BIT = 8'hA2;
	localparam logic [7:0] OP_CP_BIT_C = 8'h92;
	localparam logic [7:0] OP_BR_CARRY = 8'h40;
	localparam logic [7:0] OP_BR_NO_CARRY = 8'h50;
	localparam logic [7:0] OP_BR_ACC_ZERO = 8'h60;
	localparam logic [7:0] OP_BR_ACC_NZ = 8'h70;
	localparam logic [7:0] OP_BR_BIT_HI_CLR = 8'h10;
	localparam logic [7:0] OP_BR_BIT_HI = 8'h20;
	localparam logic [7:0] OP_BR_BIT_LO = 8'h30;
	localparam logic [7:0] OP_CMPB_A_IMM = 8'hB4;
	localparam logic [7:0] OP_CMPB_A_DIR = 8'hB5;
	localparam logic [7:0] OP_DECB_DIR = 8'hD5;
	localparam logic [7:0] OP_FAR_JUMP = 8'h02;
	localparam logic [7:0] OP_FAR_CALL = 8'h12;
	localparam logic [7:0] OP_SUB_RETURN = 8'h22;
	localparam logic [7:0] OP_INT_RETURN = 8'h32;
	localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
	localparam logic [7:0] OP_IND_JUMP = 8'h73;

	// ----------------------------------------------------------------
	// opcode prefixes: bank register (top 5), pointer (top 7), page (low 5)
	// ----------------------------------------------------------------
	localparam logic [4:0] PX_CP_A_RN = 5'h1D;
	localparam logic [4:0] PX_CP_RN_A = 5'h1F;
	localparam logic [4:0] PX_CP_RN_DIR = 5'h15;
	localparam logic [4:0] PX_CP_RN_IMM = 5'h0F;
	localparam logic [4:0] PX_CP_DIR_RN = 5'h11;
	localparam logic [4:0] PX_EXG_RN = 5'h19;
	localparam logic [4:0] PX_CMPB_RN = 5'h17;
	localparam logic [4:0] PX_DECB_RN = 5'h1B;
	localparam logic [6:0] PX_CP_A_RI = 7'h73;
	localparam logic [6:0] PX_CP_DIR_RI = 7'h43;
	localparam logic [6:0] PX_CP_RI_A = 7'h7B;
	localparam logic [6:0] PX_CP_RI_DIR = 7'h53;
	localparam logic [6:0] PX_CP_RI_IMM = 7'h3B;
	localparam logic [6:0] PX_EXT_RD_RI = 7'h71;
	localparam logic [6:0] PX_EXT_WR_RI = 7'h79;
	localparam logic [6:0] PX_EXG_RI = 7'h63;
	localparam logic [6:0] PX_NIB_EXG_RI = 7'h6B;
	localparam logic [6:0] PX_CMPB_RI = 7'h5B;
	localparam logic [4:0] PX_PAGE_JUMP = 5'h01;
	localparam logic [4:0] PX_PAGE_CALL = 5'h11;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {AM_NONE, AM_REG, AM_IND, AM_DIR, AM_BIT,
		AM_IMM, AM_EXT_RI, AM_EXT_DP} mcit_amode_t;
	typedef enum logic [2:0] {TM_NONE, TM_REL, TM_PAGE, TM_FULL,
		TM_ACC_DP, TM_ACC_PC, TM_DP} mcit_tmode_t;
	typedef enum logic [3:0] {CD_NONE, CD_ALWAYS, CD_CARRY, CD_NO_CARRY,
		CD_ACC_ZERO, CD_ACC_NZ, CD_BIT_HI, CD_BIT_LO, CD_NE,
		CD_DEC_NZ} mcit_cond_t;
	typedef enum logic [2:0] {SP_NONE, SP_RAM_LO, SP_SFR, SP_RAM_HI,
		SP_EXT, SP_CODE} mcit_space_t;
	typedef enum logic {PH_IDLE, PH_EXEC} mcit_phase_t;

	typedef struct packed {
		logic [1:0] len;
		logic [2:0] cyc;
		logic [2:0] cyc_tk;
		mcit_amode_t am;
		mcit_tmode_t tm;
		mcit_cond_t cond;
		logic known;
	} mcit_dec_t;

	typedef struct packed {
		mcit_phase_t phase;
		logic [2:0] cnt;
		logic [1:0] len;
		logic [2:0] cyc;
		logic known;
		logic taken;
		logic [PC_W-1:0] target;
		mcit_tmode_t tk;
		logic [7:0] addr;
		mcit_space_t space;
	} mcit_state_t;

	function automatic mcit_dec_t row(input logic [1:0] l,
		input logic [2:0] c, input logic [2:0] t, input mcit_amode_t a,
		input mcit_tmode_t m, input mcit_cond_t k);
		mcit_dec_t d;
		d.len = l;
		d.cyc = c;
		d.cyc_tk = t;
		d.am = a;
		d.tm = m;
		d.cond = k;
		d.known = 1'b1;
		return d;
	endfunction : row

endpackage : mcit_pkg

// ===== core/mcit_target.sv
/*
 * Target address former: relative, in-page, full, and accumulator
 * indexed addresses for branches and code reads.
 * Assumes the caller supplies the address of the following instruction.
 */
`timescale 1ns/1ns
module mcit_target (
	// address sources
	input wire logic [mcit_pkg::PC_W-1:0] pc_next,
	input wire mcit_pkg::mcit_tmode_t mode,
	input wire logic [7:0] rel,
	input wire logic [mcit_pkg::PAGE_W-1:0] page,
	input wire logic [mcit_pkg::PC_W-1:0] full,
	input wire logic [7:0] acc,
	input wire logic [mcit_pkg::PC_W-1:0] dp,
	// result
	output logic [mcit_pkg::PC_W-1:0] target
);
	import mcit_pkg::*;

	// wraps at the top of the 64K space, as the program counter does
	function automatic logic [PC_W-1:0] add16(
		input logic [PC_W-1:0] base, input logic [PC_W-1:0] off);
		return PC_W'(base + off);
	endfunction : add16

	always_comb begin
		unique case (mode)
			TM_REL: target = add16(pc_next, {{8{rel[7]}}, rel});
			TM_PAGE: target = {pc_next[PC_W-1:PAGE_W], page};
			TM_FULL: target = full;
			TM_ACC_DP: target = add16(dp, {8'h00, acc});
			TM_ACC_PC: target = add16(pc_next, {8'h00, acc});
			TM_DP: target = dp;
			default: target = pc_next;
		endcase
	end

endmodule : mcit_target

// ===== core/mcit_core_timing.sv
/*
 * Instruction decode and execution timing for an 8-bit controller core:
 * encoding length, cycle count, operand address and space, branch target.
 * Assumes a datapath that offers one opcode with its operand bytes,
 * supplies the flags and operand values, and holds offers until ready.
 */
`timescale 1ns/1ns
module mcit_core_timing (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// instruction offer
	input wire logic instr_valid,
	output logic instr_ready,
	input wire logic [7:0] opcode,
	input wire logic [7:0] operand1,
	input wire logic [7:0] operand2,
	input wire logic [mcit_pkg::PC_W-1:0] instr_pc,
	// machine state
	input wire logic [7:0] program_status_word,
	input wire logic [7:0] acc,
	input wire logic carry,
	input wire logic tested_bit,
	input wire logic [7:0] lhs_value,
	input wire logic [7:0] rhs_value,
	input wire logic [7:0] ptr_value,
	input wire logic [mcit_pkg::PC_W-1:0] data_pointer,
	// pointer register lookup
	output logic [7:0] ptr_reg_addr,
	// results
	output logic instr_done,
	output logic [1:0] instr_len,
	output logic [2:0] exec_cycles,
	output logic known_op,
	output logic branch_taken,
	output logic [mcit_pkg::PC_W-1:0] target_addr,
	output mcit_pkg::mcit_tmode_t target_kind,
	output logic [7:0] op_addr,
	output mcit_pkg::mcit_space_t op_space
);
	import mcit_pkg::*;

	// ----------------------------------------------------------------
	// decode table
	// ----------------------------------------------------------------
	function automatic mcit_dec_t decode(input logic [7:0] op);
		mcit_dec_t d;
		d = row(LEN_ONE, CYC_ONE, CYC_ONE, AM_NONE, TM_NONE, CD_NONE);
		casez (op)
			OP_IDLE, OP_SPARE, OP_ROTR_CARRY, OP_NIB_SWAP, OP_CARRY_CLR,
			OP_CARRY_SET, OP_CARRY_CPL: d.known = 1'b1;
			{PX_CP_A_RN, 3'b???}, {PX_CP_RN_A, 3'b???}, {PX_EXG_RN, 3'b???}:
				d = row(LEN_ONE, CYC_ONE, CYC_ONE, AM_REG, TM_NONE,
					CD_NONE);
			{PX_CP_A_RI, 1'b?}, {PX_CP_RI_A, 1'b?}, {PX_EXG_RI, 1'b?},
			{PX_NIB_EXG_RI, 1'b?}:
				d = row(LEN_ONE, CYC_TWO, CYC_TWO, AM_IND, TM_NONE,
					CD_NONE);
			OP_CP_A_DIR, OP_CP_DIR_A, OP_STACK_PUT, OP_STACK_GET, OP_EXG_DIR,
			{PX_CP_RN_DIR, 3'b???}, {PX_CP_DIR_RN, 3'b???}:
				d = row(LEN_TWO, CYC_TWO, CYC_TWO, AM_DIR, TM_NONE,
					CD_NONE);
			OP_CP_A_IMM:
				d = row(LEN_TWO, CYC_TWO, CYC_TWO, AM_IMM, TM_NONE,
					CD_NONE);
			{PX_CP_RN_IMM, 3'b???}:
				d = row(LEN_TWO, CYC_TWO, CYC_TWO, AM_REG, TM_NONE,
					CD_NONE);
			{PX_CP_DIR_RI, 1'b?}, {PX_CP_RI_DIR, 1'b?}, {PX_CP_RI_IMM, 1'b?}:
				d = row(LEN_TWO, CYC_TWO, CYC_TWO, AM_IND, TM_NONE,
					CD_NONE);
			OP_CP_DD, OP_CP_DIR_IMM:
				d = row(LEN_THREE, CYC_THREE, CYC_THREE, AM_DIR, TM_NONE,
					CD_NONE);
			OP_LOAD_DP:
				d = row(LEN_THREE, CYC_THREE, CYC_THREE, AM_IMM, TM_FULL,
					CD_NONE);
			OP_CODE_DP:
				d = row(LEN_ONE, CYC_THREE, CYC_THREE, AM_NONE, TM_ACC_DP,
					CD_NONE);
			OP_CODE_PC:
				d = row(LEN_ONE, CYC_THREE, CYC_THREE, AM_NONE, TM_ACC_PC,
					CD_NONE);
			{PX_EXT_RD_RI, 1'b?}, {PX_EXT_WR_RI, 1'b?}:
				d = row(LEN_ONE, CYC_THREE, CYC_THREE, AM_EXT_RI, TM_NONE,
					CD_NONE);
			OP_EXT_RD_DP, OP_EXT_WR_DP:
				d = row(LEN_ONE, CYC_THREE, CYC_THREE, AM_EXT_DP, TM_DP,
					CD_NONE);
			OP_BIT_CLR, OP_BIT_SET, OP_BIT_CPL, OP_AND_BIT, OP_AND_NBIT,
			OP_OR_BIT, OP_OR_NBIT, OP_CP_C_BIT, OP_CP_BIT_C:
				d = row(LEN_TWO, CYC_TWO, CYC_TWO, AM_BIT, TM_NONE,
					CD_NONE);
			OP_BR_CARRY:
				d = row(LEN_TWO, CYC_TWO, CYC_THREE, AM_NONE, TM_REL,
					CD_CARRY);
			OP_BR_NO_CARRY:
				d = row(LEN_TWO, CYC_TWO, CYC_THREE, AM_NONE, TM_REL,
					CD_NO_CARRY);
			OP_BR_ACC_ZERO:
				d = row(LEN_TWO, CYC_TWO, CYC_THREE, AM_NONE, TM_REL,
					CD_ACC_ZERO);
			OP_BR_ACC_NZ:
				d = row(LEN_TWO, CYC_TWO, CYC_THREE, AM_NONE, TM_REL,
					CD_ACC_NZ);
			{PX_DECB_RN, 3'b???}:
				d = row(LEN_TWO, CYC_TWO, CYC_THREE, AM_REG, TM_REL,
					CD_DEC_NZ);
			OP_BR_BIT_HI, OP_BR_BIT_HI_CLR:
				d = row(LEN_THREE, CYC_THREE, CYC_FOUR, AM_BIT, TM_REL,
					CD_BIT_HI);
			OP_BR_BIT_LO:
				d = row(LEN_THREE, CYC_THREE, CYC_FOUR, AM_BIT, TM_REL,
					CD_BIT_LO);
			OP_CMPB_A_IMM:
				d = row(LEN_THREE, CYC_THREE, CYC_FOUR, AM_IMM, TM_REL,
					CD_NE);
			OP_CMPB_A_DIR:
				d = row(LEN_THREE, CYC_THREE, CYC_FOUR, AM_DIR, TM_REL,
					CD_NE);
			{PX_CMPB_RN, 3'b???}:
				d = row(LEN_THREE, CYC_THREE, CYC_FOUR, AM_REG, TM_REL,
					CD_NE);
			OP_DECB_DIR:
				d = row(LEN_THREE, CYC_THREE, CYC_FOUR, AM_DIR, TM_REL,
					CD_DEC_NZ);
			{PX_CMPB_RI, 1'b?}:
				d = row(LEN_THREE, CYC_FOUR, CYC_FIVE, AM_IND, TM_REL,
					CD_NE);
			OP_SHORT_JUMP:
				d = row(LEN_TWO, CYC_THREE, CYC_THREE, AM_NONE, TM_REL,
					CD_ALWAYS);
			OP_IND_JUMP:
				d = row(LEN_ONE, CYC_THREE, CYC_THREE, AM_NONE, TM_ACC_DP,
					CD_ALWAYS);
			{3'b???, PX_PAGE_JUMP}, {3'b???, PX_PAGE_CALL}:
				d = row(LEN_TWO, CYC_THREE, CYC_THREE, AM_NONE, TM_PAGE,
					CD_ALWAYS);
			OP_FAR_JUMP, OP_FAR_CALL:
				d = row(LEN_THREE, CYC_FOUR, CYC_FOUR, AM_NONE, TM_FULL,
					CD_ALWAYS);
			OP_SUB_RETURN, OP_INT_RETURN:
				d = row(LEN_ONE, CYC_FIVE, CYC_FIVE, AM_NONE, TM_NONE,
					CD_ALWAYS);
			// rows not covered here keep one byte, one cycle and known=0
			default: d.known = 1'b0;
		endcase
		return d;
	endfunction : decode

	function automatic logic cond_met(input mcit_cond_t k);
		unique case (k)
			CD_ALWAYS: return 1'b1;
			CD_CARRY: return carry;
			CD_NO_CARRY: return !carry;
			CD_ACC_ZERO: return acc == 8'h00;
			CD_ACC_NZ: return acc != 8'h00;
			CD_BIT_HI: return tested_bit;
			CD_BIT_LO: return !tested_bit;
			CD_NE: return lhs_value != rhs_value;
			// value before the decrement, so one means the result is zero
			CD_DEC_NZ: return lhs_value != 8'h01;
			default: return 1'b0;
		endcase
	endfunction : cond_met

	// ----------------------------------------------------------------
	// operand resolution
	// ----------------------------------------------------------------
	mcit_dec_t dec;
	logic [1:0] bank;
	logic taken;
	logic [7:0] res_addr;
	mcit_space_t res_space;
	logic [PC_W-1:0] pc_next;
	logic [PC_W-1:0] tgt;

	assign dec = decode(opcode);
	assign bank = program_status_word[BANK_HI_POS:BANK_LO_POS];
	// a process, since the flags are read inside the function
	always_comb taken = cond_met(dec.cond);
	assign pc_next = PC_W'(instr_pc + {{(PC_W-2){1'b0}}, dec.len});
	// only R0 or R1 of the active bank can act as a pointer
	assign ptr_reg_addr = {3'h0, bank, 2'h0, opcode[0]};

	always_comb begin
		res_addr = 8'h00;
		res_space = SP_NONE;
		unique case (dec.am)
			AM_REG: begin
				res_addr = {3'h0, bank, opcode[2:0]};
				res_space = SP_RAM_LO;
			end
			AM_IND: begin
				res_addr = ptr_value;
				res_space = ptr_value[HALF_POS] ? SP_RAM_HI
					: SP_RAM_LO;
			end
			AM_DIR: begin
				res_addr = operand1;
				res_space = operand1[HALF_POS] ? SP_SFR : SP_RAM_LO;
			end
			AM_BIT: begin
				res_addr = operand1[HALF_POS] ? {operand1[7:3], 3'h0}
					: BIT_BYTE_BASE | {4'h0, operand1[6:3]};
				res_space = operand1[HALF_POS] ? SP_SFR : SP_RAM_LO;
			end
			AM_EXT_RI: begin
				res_addr = ptr_value;
				res_space = SP_EXT;
			end
			AM_EXT_DP: res_space = SP_EXT;
			default: res_space = SP_NONE;
		endcase
		// code reads reach program space, never data space
		if (dec.tm inside {TM_ACC_PC} || opcode == OP_CODE_DP)
			res_space = SP_CODE;
	end

	mcit_target u_target (
		.pc_next(pc_next),
		.mode(dec.tm),
		.rel(dec.len == LEN_THREE ? operand2 : operand1),
		.page({opcode[7:5], operand1}),
		.full({operand1, operand2}),
		.acc(acc),
		.dp(data_pointer),
		.target(tgt)
	);

	// ----------------------------------------------------------------
	// execution sequencer
	// ----------------------------------------------------------------
	mcit_state_t s;
	mcit_state_t next_s;
	logic last, accept;

	assign last = s.phase == PH_EXEC && s.cnt == 3'h0;
	// a new offer is taken in the final cycle, so no bubble between
	assign instr_ready = s.phase == PH_IDLE || last;
	assign accept = instr_valid && instr_ready;
	assign instr_done = last;

	always_comb begin
		next_s = s;
		if (last)
			next_s.phase = PH_IDLE;
		else if (s.phase == PH_EXEC)
			next_s.cnt = 3'(s.cnt - 3'h1);
		if (accept) begin
			next_s.phase = PH_EXEC;
			next_s.cyc = taken ? dec.cyc_tk : dec.cyc;
			next_s.cnt = 3'((taken ? dec.cyc_tk : dec.cyc) - 3'h1);
			next_s.len = dec.len;
			next_s.known = dec.known;
			next_s.taken = taken && dec.cond != CD_NONE;
			next_s.target = tgt;
			next_s.tk = dec.tm;
			next_s.addr = res_addr;
			next_s.space = res_space;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			s <= '0;
		else
			s <= next_s;
	end

	assign instr_len = s.len;
	assign exec_cycles = s.cyc;
	assign known_op = s.known;
	assign branch_taken = s.taken;
	assign target_addr = s.target;
	assign target_kind = s.tk;
	assign op_addr = s.addr;
	assign op_space = s.space;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	property p_swap_one;
		accept && opcode == OP_NIB_SWAP |-> ##1 instr_done && instr_len == 2'h1;
	endproperty
	a_swap_one: assert property (p_swap_one) else $error("swap len");
	property p_exg_ind;
		accept && opcode[7:1] == PX_EXG_RI |-> ##1 !instr_done ##1 instr_done;
	endproperty
	a_exg_ind: assert property (p_exg_ind) else $error("exchange not 2");
	property p_dd;
		accept && opcode == OP_CP_DD
			|-> ##1 (!instr_done && instr_len == 2'h3)[*2] ##1 instr_done;
	endproperty
	a_dd: assert property (p_dd) else $error("dir-dir not 3/3");
	property p_ext_dp;
		accept && opcode == OP_EXT_RD_DP
			|-> ##1 op_space == SP_EXT ##2 instr_done;
	endproperty
	a_ext_dp: assert property (p_ext_dp) else $error("ext move timing");
	property p_carry_br;
		accept && opcode == OP_BR_CARRY
			|-> if (carry) ##3 instr_done else ##2 instr_done;
	endproperty
	a_carry_br: assert property (p_carry_br) else $error("carry br");
	property p_cmp_ind;
		accept && opcode[7:1] == PX_CMPB_RI && lhs_value != rhs_value
			|-> ##1 branch_taken ##4 instr_done;
	endproperty
	a_cmp_ind: assert property (p_cmp_ind) else $error("cmp ind not 5");
	property p_far;
		accept && opcode == OP_FAR_JUMP
			|-> ##1 target_addr == {$past(operand1), $past(operand2)}
			##3 instr_done;
	endproperty
	a_far: assert property (p_far) else $error("far jump wrong");
	property p_rel;
		accept && opcode == OP_SHORT_JUMP |-> ##1 target_addr ==
			16'($past(instr_pc) + 16'h0002
			+ {{8{$past(operand1[7])}}, $past(operand1)});
	endproperty
	a_rel: assert property (p_rel) else $error("relative target wrong");
	property p_dir_space;
		accept && opcode == OP_CP_A_DIR |-> ##1 op_space ==
			($past(operand1[7]) ? SP_SFR : SP_RAM_LO);
	endproperty
	a_dir_space: assert property (p_dir_space) else $error("space");
	property p_spare;
		accept && opcode == OP_SPARE |-> ##1 instr_done && known_op;
	endproperty
	a_spare: assert property (p_spare) else $error("spare not idle");
	property p_bank;
		accept && opcode[7:3] == PX_CP_A_RN |-> ##1 op_addr[4:3]
			== $past(program_status_word[BANK_HI_POS:BANK_LO_POS]);
	endproperty
	a_bank: assert property (p_bank) else $error("bank select wrong");
	c_taken: cover property (accept && taken && dec.cyc_tk == CYC_FOUR);
	c_back: cover property (last && accept);
	c_upper: cover property (accept && res_space == SP_RAM_HI);

endmodule : mcit_core_timing

// ===== verification/mcit_testbench.sv
/*
 * Self-checking bench for the decode and timing block: encoding lengths,
 * cycle counts, branch outcomes, targets and operand spaces.
 * Assumes the block's own assertions; the bench drives every port itself.
 */
`timescale 1ns/1ns
module testbench;
	import mcit_pkg::*;
	logic core_clk = 1'b0, nrst = 1'b0, instr_valid = 1'b0, carry = 1'b0;
	logic tested_bit = 1'b0, instr_ready, instr_done, known_op, branch_taken;
	logic [7:0] opcode = 8'h00, operand1 = 8'h00, operand2 = 8'h00;
	logic [7:0] program_status_word = 8'h00, acc = 8'h00, lhs_value = 8'h00;
	logic [7:0] rhs_value = 8'h00, ptr_value = 8'h00, ptr_reg_addr, op_addr;
	logic [15:0] instr_pc = 16'h0000, data_pointer = 16'h0000, target_addr;
	logic [1:0] instr_len;
	logic [2:0] exec_cycles;
	mcit_tmode_t target_kind;
	mcit_space_t op_space;
	int n_fail = 0, n_compared = 0, ncyc;
	always #4 core_clk = ~core_clk;
	mcit_core_timing uut (.core_clk(core_clk), .nrst(nrst),
		.instr_valid(instr_valid), .instr_ready(instr_ready), .opcode(opcode),
		.operand1(operand1), .operand2(operand2), .instr_pc(instr_pc),
		.program_status_word(program_status_word), .acc(acc), .carry(carry),
		.tested_bit(tested_bit), .lhs_value(lhs_value), .rhs_value(rhs_value),
		.ptr_value(ptr_value), .data_pointer(data_pointer),
		.ptr_reg_addr(ptr_reg_addr), .instr_done(instr_done),
		.instr_len(instr_len), .exec_cycles(exec_cycles), .known_op(known_op),
		.branch_taken(branch_taken), .target_addr(target_addr),
		.target_kind(target_kind), .op_addr(op_addr), .op_space(op_space));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop
	// offer held until taken, then edges counted up to done
	task automatic run(input logic [7:0] op, o1, o2, input logic [15:0] pc);
		int k;
		k = 0;
		@(posedge core_clk);
		instr_valid <= 1'b1;
		opcode <= op;
		operand1 <= o1;
		operand2 <= o2;
		instr_pc <= pc;
		do begin
			@(negedge core_clk);
			k++;
		end while (instr_ready !== 1'b1 && k < 20);
		if (instr_ready !== 1'b1)
			n_fail++;
		@(posedge core_clk);
		instr_valid <= 1'b0;
		ncyc = 0;
		do begin
			@(negedge core_clk);
			ncyc++;
		end while (instr_done !== 1'b1 && ncyc < 20);
	endtask : run
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		@(negedge core_clk);
		chk("ready", instr_ready, 1'b1);
		chk("done", instr_done, 1'b0);
		chk("cycles", exec_cycles, 3'h0);
		chk("space", op_space, SP_NONE);
	endtask : t_reset
	task automatic t_table;
		logic [7:0] op [24] = '{8'h13, 8'hC4, 8'hE8, 8'hE6, 8'hE5, 8'h74,
			8'h85, 8'h75, 8'h90, 8'h93, 8'h83, 8'hE2, 8'hF0, 8'hC0, 8'hD0,
			8'hD6, 8'hC3, 8'h92, 8'h80, 8'h73, 8'h12, 8'h00, 8'hA5, 8'h22};
		int ln [24] = '{1, 1, 1, 1, 2, 2, 3, 3, 3, 1, 1, 1, 1, 2, 2,
			1, 1, 2, 2, 1, 3, 1, 1, 1};
		int cy [24] = '{1, 1, 1, 2, 2, 2, 3, 3, 3, 3, 3, 3, 3, 2, 2,
			2, 1, 2, 3, 3, 4, 1, 1, 5};
		for (int i = 0; i < 24; i++) begin
			run(op[i], 8'h30, 8'h40, 16'h0100);
			chk("len", instr_len, 16'(ln[i]));
			chk("cycles", 16'(ncyc), 16'(cy[i]));
			chk("exec", exec_cycles, 16'(cy[i]));
			chk("known", known_op, 1'b1);
		end
	endtask : t_table
	task automatic t_branch;
		@(posedge core_clk) carry <= 1'b0;
		run(8'h40, 8'hFE, 8'h00, 16'h1000);
		chk("jc nt cyc", 16'(ncyc), 16'd2);
		chk("jc nt", branch_taken, 1'b0);
		@(posedge core_clk) carry <= 1'b1;
		run(8'h40, 8'hFE, 8'h00, 16'h1000);
		chk("jc t cyc", 16'(ncyc), 16'd3);
		chk("jc tgt", target_addr, 16'h1000);
		@(posedge core_clk) tested_bit <= 1'b1;
		run(8'h20, 8'h05, 8'h80, 16'h2000);
		chk("jb t cyc", 16'(ncyc), 16'd4);
		chk("jb tgt", target_addr, 16'h1F83);
		@(posedge core_clk) tested_bit <= 1'b0;
		run(8'h20, 8'h05, 8'h80, 16'h2000);
		chk("jb nt cyc", 16'(ncyc), 16'd3);
		@(posedge core_clk) lhs_value <= 8'h12;
		run(8'hB6, 8'h12, 8'h10, 16'h0000);
		chk("cmp t cyc", 16'(ncyc), 16'd5);
		@(posedge core_clk) rhs_value <= 8'h12;
		run(8'hB6, 8'h12, 8'h10, 16'h0000);
		chk("cmp nt cyc", 16'(ncyc), 16'd4);
		chk("cmp len", instr_len, 2'h3);
	endtask : t_branch
	task automatic t_jumps;
		run(8'hA1, 8'h34, 8'h00, 16'h27FE);
		chk("page tgt", target_addr, 16'h2D34);
		chk("page cyc", 16'(ncyc), 16'd3);
		chk("page kind", target_kind, TM_PAGE);
		run(8'h02, 8'hAB, 8'hCD, 16'h0010);
		chk("far tgt", target_addr, 16'hABCD);
		chk("far cyc", 16'(ncyc), 16'd4);
		chk("far taken", branch_taken, 1'b1);
	endtask : t_jumps
	task automatic t_space;
		run(8'hE5, 8'h85, 8'h00, 16'h0000);
		chk("sfr", op_space, SP_SFR);
		chk("dir addr", op_addr, 8'h85);
		run(8'hE5, 8'h10, 8'h00, 16'h0000);
		chk("ram lo", op_space, SP_RAM_LO);
		@(posedge core_clk) program_status_word <= 8'h18;
		ptr_value <= 8'h90;
		run(8'hE7, 8'h00, 8'h00, 16'h0000);
		chk("ptr reg", ptr_reg_addr, 8'h19);
		chk("ram hi", op_space, SP_RAM_HI);
		chk("ind addr", op_addr, 8'h90);
		@(posedge core_clk) program_status_word <= 8'h10;
		run(8'hED, 8'h00, 8'h00, 16'h0000);
		chk("bank reg", op_addr, 8'h15);
		run(8'h93, 8'h00, 8'h00, 16'h0000);
		chk("code", op_space, SP_CODE);
		run(8'hE0, 8'h00, 8'h00, 16'h0000);
		chk("ext", op_space, SP_EXT);
	endtask : t_space
	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		t_reset();
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		t_table();
		t_branch();
		t_jumps();
		t_space();
		report_and_stop();
	end
	initial begin
		// about 40 offers of up to 8 cycles each; ample margin
		#20000;
		n_fail++;
		report_and_stop();
	end
endmodule : testbench
